// ---- core/hbgp_core.sv ----
`timescale 1ns/10ps
module hbgp_core
	import hbgp_pkg::*;
#(
	parameter logic [31:0] POR_CYC = 32'(POR_CYC_DEF)
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Controller side
	input wire logic high_side_cmd,
	input wire logic low_side_cmd,
	input wire logic shutdown_request_n,
	// Power side
	input wire logic high_side_desat_sense,
	input wire logic low_side_desat_sense,
	input wire logic supply_undervoltage_trip,
	output logic high_side_gate,
	output logic low_side_gate,
	// Open-collector fault pin
	output logic fault_indicator_out,
	output logic fault_indicator_oe,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ==========================================================
	// State and working signals
	hbgp_state_type s_q;
	hbgp_state_type s_d;
	logic [1:0] cmd;
	logic [1:0] sense;
	logic [1:0] desat;
	logic [CAUSE_W-1:0] src;
	logic hold_low;
	logic block;
	logic [31:0] status;
	int oth;

	// Channel 0 is high side, channel 1 low side
	assign cmd = {low_side_cmd, high_side_cmd};
	assign sense = {low_side_desat_sense, high_side_desat_sense};

	// Status word seen by software
	always_comb
	begin
		status = '0;
		status[ST_FAULT_BIT] = s_q.fault;
		status[ST_POR_BIT] = s_q.por_done;
		status[ST_HS_GATE_BIT] = s_q.gate[0];
		status[ST_LS_GATE_BIT] = s_q.gate[1];
		status[ST_HS_FILT_BIT] = s_q.filt[0];
		status[ST_LS_FILT_BIT] = s_q.filt[1];
		status[ST_CAUSE_LSB +: CAUSE_W] = s_q.cause;
	end

	// ==========================================================
	// Next state of the whole block
	always_comb
	begin
		s_d = s_q;
		oth = 0;

		// Power-on hold counter
		if (!s_q.por_done)
		begin
			s_d.pcnt = s_q.pcnt + 32'h00000001;
			if (s_q.pcnt == POR_CYC - 32'h00000001)
			begin
				s_d.por_done = 1'b1;
			end
		end

		// Desat only after blanking, per channel
		for (int c = 0; c < 2; c++)
		begin
			desat[c] = s_q.gate[c] & (s_q.bcnt[c] == BLANK_CYC) & sense[c];
		end

		// Fault sources gathered
		src = '0;
		src[CS_UV] = supply_undervoltage_trip;
		src[CS_SDI] = ~shutdown_request_n;
		src[CS_DS_HS] = desat[0];
		src[CS_DS_LS] = desat[1];
		src[CS_SOFT] = s_q.soft_sd;
		hold_low = (src == '0) & ~high_side_cmd & ~low_side_cmd;

		// Fault latch: a present source always wins over clearing
		if (src != '0)
		begin
			s_d.fault = 1'b1;
			s_d.cause = s_q.cause | src;
			s_d.ccnt = '0;
		end
		else if (s_q.fault && hold_low)
		begin
			if (s_q.ccnt == CLR_CYC - 12'h001)
			begin
				s_d.fault = 1'b0;
				s_d.cause = '0;
				s_d.ccnt = '0;
			end
			else
			begin
				s_d.ccnt = s_q.ccnt + 12'h001;
			end
		end
		else
		begin
			s_d.ccnt = '0;
		end

		// Commands blocked by fault or power-on hold
		block = s_d.fault | ~s_q.por_done;

		// Per-channel filter, interlock and blanking
		for (int c = 0; c < 2; c++)
		begin
			oth = 1 - c;

			// Glitch filter: level must hold for the whole window
			if (cmd[c] != s_q.filt[c])
			begin
				if (s_q.fcnt[c] == FILT_CYC - 12'h001)
				begin
					s_d.filt[c] = cmd[c];
					s_d.fcnt[c] = '0;
				end
				else
				begin
					s_d.fcnt[c] = s_q.fcnt[c] + 12'h001;
				end
			end
			else
			begin
				s_d.fcnt[c] = '0;
			end

			// Interlock; high side decided first, low side sees it
			if (!s_q.filt[c] || block)
			begin
				s_d.gate[c] = 1'b0;
			end
			else if (!s_q.gate[c] && !s_d.gate[oth] && s_q.ocnt[oth] == DEAD_CYC)
			begin
				s_d.gate[c] = 1'b1;
			end

			// Off-time counter of this channel, saturating
			if (s_d.gate[c])
			begin
				s_d.ocnt[c] = '0;
			end
			else if (s_q.ocnt[c] != DEAD_CYC)
			begin
				s_d.ocnt[c] = s_q.ocnt[c] + 12'h001;
			end

			// Blanking counter restarts at every turn-off
			if (!s_d.gate[c])
			begin
				s_d.bcnt[c] = '0;
			end
			else if (s_q.bcnt[c] != BLANK_CYC)
			begin
				s_d.bcnt[c] = s_q.bcnt[c] + 12'h001;
			end
		end

		// Indicator pulled low only when healthy
		s_d.ind_oe = s_d.por_done & ~s_d.fault;
		s_d.ind_out = 1'b0;

		// Write address and data, taken in either order
		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.aw_have = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.w_have = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end

		// Perform write once both halves are held
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			unique case (s_q.awaddr)
				REG_CTRL:
				begin
					if (s_q.wstrb[0])
					begin
						s_d.soft_sd = s_q.wdata[CTRL_SOFT_BIT];
					end
				end
				REG_STATUS:
				begin
					s_d.bresp = RESP_OKAY;
				end
				default:
				begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		else if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
		end

		// Read channel
		if (s_axi_arvalid && s_q.arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL:
				begin
					s_d.rdata = '0;
					s_d.rdata[CTRL_SOFT_BIT] = s_q.soft_sd;
				end
				REG_STATUS:
				begin
					s_d.rdata = status;
				end
				default:
				begin
					s_d.rdata = '0;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		else if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
		end

		// Ready only while idle, from next state
		s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
		s_d.wready = ~s_d.w_have & ~s_d.bvalid;
		s_d.arready = ~s_d.rvalid;
	end

	// ==========================================================
	// State register, frozen while clock enable is low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
		end
		else if (clk_en)
		begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	assign high_side_gate = s_q.gate[0];
	assign low_side_gate = s_q.gate[1];
	assign fault_indicator_out = s_q.ind_out;
	assign fault_indicator_oe = s_q.ind_oe;
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;

endmodule

// ---- common/hbgp_pkg.sv ----
// What this block does
// - Reject command pulses under 625 ns
// - Always pass command pulses over 750 ns
// - Filter threshold lies inside 625-750 ns
// - Any fault sets latch and indicator
// - Latched fault ignores all commands
// - Latched fault keeps switches off
// - Clear needs no fault, inputs low >9us
// - Open-collector indicator: released means error
// - Low shutdown input sets fault latch
// - Shutdown clear needs input high, >9us low
// - Shutdown input defaults to inactive high
// - Never both switches on together
// - Dead time is max, never added
// - Inverted low command works via interlock
// - Dead time fixed, not configurable
// - Command overlap raises no fault
// - Desat after blanking trips channel, fault
// - Desat ignored during blanking after turn-on
// - Turn-off restarts the blanking interval
// - Commands active high: high means on
// - Undervoltage forces off and sets fault
// - Outputs off during 150 ms power-on
package hbgp_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_NS = 4;
	localparam int FILT_NS = 650;
	localparam int DEAD_NS = 1000;
	localparam int BLANK_NS = 5000;
	localparam int CLR_NS = 9000;
	localparam int POR_MS = 150;
	localparam int NS_PER_MS = 1000000;
	localparam logic [11:0] FILT_CYC = 12'((FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] DEAD_CYC = 12'((DEAD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] BLANK_CYC = 12'((BLANK_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] CLR_CYC = 12'(CLR_NS / CLK_NS + 1);
	localparam int POR_CYC_DEF = POR_MS * NS_PER_MS / CLK_NS;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam int CTRL_SOFT_BIT = 0;
	localparam int ST_FAULT_BIT = 0;
	localparam int ST_POR_BIT = 1;
	localparam int ST_HS_GATE_BIT = 2;
	localparam int ST_LS_GATE_BIT = 3;
	localparam int ST_HS_FILT_BIT = 4;
	localparam int ST_LS_FILT_BIT = 5;
	localparam int ST_CAUSE_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Fault cause bits
	localparam int CAUSE_W = 5;
	localparam int CS_UV = 0;
	localparam int CS_SDI = 1;
	localparam int CS_DS_HS = 2;
	localparam int CS_DS_LS = 3;
	localparam int CS_SOFT = 4;

	// ==========================================================
	// Whole block state
	typedef struct packed {
		logic [1:0] filt;
		logic [1:0][11:0] fcnt;
		logic [1:0] gate;
		logic [1:0][11:0] ocnt;
		logic [1:0][11:0] bcnt;
		logic fault;
		logic [CAUSE_W-1:0] cause;
		logic [11:0] ccnt;
		logic [31:0] pcnt;
		logic por_done;
		logic ind_oe;
		logic ind_out;
		logic soft_sd;
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} hbgp_state_type;

endpackage

// ---- bench/hbgp_checker.sv ----
`timescale 1ns/10ps
// ========
// Protection checker
module hbgp_checker
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic high_side_cmd,
	input wire logic low_side_cmd,
	input wire logic shutdown_request_n,
	input wire logic supply_undervoltage_trip,
	input wire logic high_side_gate,
	input wire logic low_side_gate,
	input wire logic fault_indicator_oe
);
	logic [3:0][7:0] run_q;
	logic [3:0] stop;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Saturating counts of gates off and commands low
	assign stop = {low_side_cmd, high_side_cmd, low_side_gate, high_side_gate};
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			run_q[i] <= !aresetn ? 8'hFF : stop[i] ? 8'h00 : run_q[i] + 8'(run_q[i] != 8'hFF);
		end
	end
	chk_no_overlap: assert property (!(high_side_gate && low_side_gate))
		else $error("both gates on");
	chk_uv_trip: assert property (supply_undervoltage_trip |=> !fault_indicator_oe && !high_side_gate)
		else $error("undervoltage missed");
	chk_sdi_trip: assert property (!shutdown_request_n |=> !fault_indicator_oe)
		else $error("shutdown missed");
	chk_fault_off: assert property (!fault_indicator_oe |-> !high_side_gate && !low_side_gate)
		else $error("gate on in fault");
	chk_hs_dead: assert property ($rose(high_side_gate) |-> run_q[1] > 8'hF8)
		else $error("high dead time short");
	chk_ls_dead: assert property ($rose(low_side_gate) |-> run_q[0] > 8'hF8)
		else $error("low dead time short");
	chk_hs_quiet: assert property (run_q[2] > 8'hA5 |-> !high_side_gate)
		else $error("high gate stuck on");
	chk_ls_quiet: assert property (run_q[3] > 8'hA5 |-> !low_side_gate)
		else $error("low gate stuck on");
endmodule
bind hbgp_core hbgp_checker hbgp_checker_i (.*);

// ---- bench/hbgp_ctrl_model.sv ----
`timescale 1ns/10ps
// ========
// Controller model
module hbgp_ctrl_model
(
	input wire logic aclk,
	output logic high_side_cmd,
	output logic low_side_cmd
);
	// Both off through power-up
	initial
	begin
		high_side_cmd = 1'h0;
		low_side_cmd = 1'h0;
	end
	// Hold one command pair for n cycles
	task automatic drive(input logic h, input logic l, input int n);
		@(posedge aclk);
		high_side_cmd <= h;
		low_side_cmd <= l;
		repeat (n - 1) @(posedge aclk);
	endtask
endmodule

// ---- bench/hbgp_bench.sv ----
`timescale 1ns/10ps
// ========
// Bench top
module hbgp_bench
	import hbgp_pkg::*;
;
	logic aclk, hc, lc, gh, gl, fo, foe, awr, wrdy, bv, arr, rv;
	logic aresetn = 1'h0, sdn = 1'h1, uv = 1'h0, awv = 1'h0, wv = 1'h0;
	logic bready = 1'h0, arv = 1'h0, rready = 1'h0;
	logic ce = 1'h1;
	logic [1:0] ds = 2'h0, bsp, rsp;
	logic [3:0] aw = 4'h0, ar = 4'h0;
	logic [31:0] wd = 32'h0, rdat;
	int num_errors = 0;
	int total_checks = 0;
	// Fault pin with pull-up
	wire pin = foe ? fo : 1'h1;
	hbgp_core #(.POR_CYC(32'h10)) hbgp_core_i
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(ce),
		.high_side_cmd(hc),
		.low_side_cmd(lc),
		.shutdown_request_n(sdn),
		.high_side_desat_sense(ds[0]),
		.low_side_desat_sense(ds[1]),
		.supply_undervoltage_trip(uv),
		.high_side_gate(gh),
		.low_side_gate(gl),
		.fault_indicator_out(fo),
		.fault_indicator_oe(foe),
		.s_axi_awaddr(aw),
		.s_axi_awvalid(awv),
		.s_axi_awready(awr),
		.s_axi_wdata(wd),
		.s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv),
		.s_axi_wready(wrdy),
		.s_axi_bresp(bsp),
		.s_axi_bvalid(bv),
		.s_axi_bready(bready),
		.s_axi_araddr(ar),
		.s_axi_arvalid(arv),
		.s_axi_arready(arr),
		.s_axi_rdata(rdat),
		.s_axi_rresp(rsp),
		.s_axi_rvalid(rv),
		.s_axi_rready(rready)
	);
	hbgp_ctrl_model hbgp_ctrl_model_i
	(
		.aclk(aclk),
		.high_side_cmd(hc),
		.low_side_cmd(lc)
	);
	// Clock, 4 ns period
	initial
	begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tend(input string n);
		$display("test %s done", n);
	endtask
	task automatic cmd(input logic h, input logic l, input int n);
		hbgp_ctrl_model_i.drive(h, l, n);
	endtask
	// Hold commands low until the latch clears
	task automatic clr;
		cmd(0, 0, 2200);
		chk(pin, 32'h1);
		cmd(0, 0, 100);
		chk(pin, 32'h0);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta;
		logic tw;
		ta = 1'h0;
		tw = 1'h0;
		@(posedge aclk);
		aw <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		while (!(ta && tw))
		begin
			@(posedge aclk);
			ta = ta || awr;
			tw = tw || wrdy;
			awv <= !ta;
			wv <= !tw;
		end
		do @(posedge aclk); while (!bv);
		bready <= 1'h0;
		chk(32'(bsp), 32'(r));
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		ar <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arr);
		arv <= 1'h0;
		do @(posedge aclk); while (!rv);
		rready <= 1'h0;
		chk(rdat, d);
		chk(32'(rsp), 32'(r));
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#200000;
		num_errors++;
		final_report;
	end
	// Test sequence
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		cmd(0, 0, 8);
		chk({gh, gl, pin}, 32'h1);
		cmd(0, 0, 2300);
		chk(pin, 32'h0);
		tend("power-on");
		cmd(1, 0, 150);
		cmd(0, 0, 20);
		chk(gh, 32'h0);
		cmd(1, 0, 400);
		chk(gh, 32'h1);
		cmd(0, 0, 150);
		cmd(1, 0, 20);
		chk(gh, 32'h1);
		tend("filter");
		cmd(0, 1, 300);
		chk({gh, gl}, 32'h0);
		cmd(0, 1, 150);
		chk(gl, 32'h1);
		cmd(0, 0, 300);
		cmd(1, 0, 170);
		chk(gh, 32'h1);
		cmd(1, 1, 400);
		chk({gh, gl, pin}, 32'h4);
		tend("interlock");
		uv <= 1'h1;
		cmd(1, 0, 5);
		uv <= 1'h0;
		chk({gh, pin}, 32'h1);
		cmd(1, 0, 300);
		chk(gh, 32'h0);
		clr;
		sdn <= 1'h0;
		cmd(1, 0, 10);
		chk(pin, 32'h1);
		cmd(0, 0, 2400);
		chk({gh, pin}, 32'h1);
		sdn <= 1'h1;
		clr;
		tend("shutdown");
		for (int s = 0; s < 2; s++)
		begin
			cmd(s == 0, s == 1, 300);
			ds[s] <= 1'h1;
			cmd(s == 0, s == 1, 800);
			chk({gh, gl, pin}, 32'h4 >> s);
			ds[s] <= 1'h0;
			cmd(s == 0, s == 1, 400);
			ds[s] <= 1'h1;
			cmd(s == 0, s == 1, 5);
			chk({gh, gl, pin}, 32'h1);
			ds[s] <= 1'h0;
			clr;
		end
		tend("desat");
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		cmd(0, 0, 5);
		chk(pin, 32'h1);
		rd(REG_STATUS, 32'h3 | (32'h1 << (ST_CAUSE_LSB + CS_SOFT)), RESP_OKAY);
		rd(4'h8, 32'h0, RESP_SLVERR);
		wr(REG_CTRL, 32'h0, RESP_OKAY);
		clr;
		rd(REG_STATUS, 32'h2, RESP_OKAY);
		tend("registers");
		// Second reset in mid-run, then power-on hold again
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		chk({gh, gl, pin}, 32'h1);
		aresetn <= 1'h1;
		cmd(0, 0, 8);
		chk({gh, gl, pin}, 32'h1);
		cmd(0, 0, 300);
		chk(pin, 32'h0);
		// Clock enable low freezes the filter and gates
		ce <= 1'h0;
		cmd(1, 0, 400);
		chk(gh, 32'h0);
		ce <= 1'h1;
		cmd(1, 0, 400);
		chk(gh, 32'h1);
		cmd(0, 0, 300);
		chk(gh, 32'h0);
		tend("reset and enable");
		final_report;
	end
endmodule
